/* File: hdl/rcd_pin_sync.sv */
// three-stage synchroniser for a level from outside the clock domain
// assumes the level is slow compared to the clock
`timescale 1ns/1ps
module rcd_pin_sync #(
	parameter logic IDLE = 1'b0
) (
	input  wire logic clock_in,
	input  wire logic arst_n_in,
	input  wire logic level_in,
	output logic      level_out
);

	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			stage1 <= IDLE;
			stage2 <= IDLE;
			stage3 <= IDLE;
		end
		else
		begin
			stage1 <= level_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// change taken once stages two and three agree
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			level_out <= IDLE;
		else if (stage2 == stage3)
			level_out <= stage3;
	end

endmodule // rcd_pin_sync

/* File: hdl/rcd_pkg.sv */
// constants, state and carrier types for the reset cause block
// assumes one 10 MHz clock and an 8-bit register port inside the device
package rcd_pkg;

	localparam int          CLOCK_HZ          = 10_000_000;
	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 8;

	// register addresses on the internal port
	localparam logic [7:0]  STATUS_ADDR       = 8'h00;
	localparam logic [7:0]  FORCE_ADDR        = 8'h01;

	// status bit positions
	localparam int          BIT_POR           = 7;
	localparam int          BIT_PIN           = 6;
	localparam int          BIT_WDOG          = 5;
	localparam int          BIT_ILLEGAL       = 4;
	localparam int          BIT_CLKGEN        = 2;
	localparam int          BIT_LV            = 1;

	// force reset bit position
	localparam int          BIT_FORCE         = 0;

	// read values
	localparam logic [7:0]  FORCE_READ_VAL    = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ_VAL = 8'h00;

	// flag values after power-on
	localparam logic        POR_FLAG_RST      = 1'b1;
	localparam logic        LV_FLAG_RST       = 1'b1;
	localparam logic        SRC_FLAG_RST      = 1'b0;

	// reset hold length in clock cycles
	localparam int          RESET_HOLD_CYCLES = 8;
	localparam int          HOLD_CNT_W        = 4;

	// synchroniser idle values
	localparam logic        PIN_IDLE          = 1'b1;
	localparam logic        LV_TRIP_IDLE      = 1'b0;

	typedef enum logic
	{
		st_run,
		st_hold
	} rcd_state_t;

	// reset sources seen in one cycle
	typedef struct packed
	{
		logic pin;
		logic wdog;
		logic illegal;
		logic clkgen;
		logic lvr;
		logic dbg;
	} rcd_src_t;

endpackage

/* File: hdl/rcd_reset_cause.sv */
// reset source capture, watchdog restart strobe and debug forced reset
// assumes arst_n_in is the power-on reset; other sources arrive as inputs
// Functional notes
// - debug forced reset leaves all flags clear
// - status write restarts watchdog, flags kept
// - power-on sets bits 7 and 1 only
// - low-voltage reset keeps bit 7, sets bit 1
// - other resets clear 7,1; flag active sources
// - pin low level sets bit 6
// - watchdog timeout sets bit 5 when enabled
// - illegal opcode, stop without stop enable, background without debug enable set bit 4
// - clock generator reset sets bit 2
// - low-voltage reset needs both enables, stop gating
// - force register reads always zero
// - user writes to force register ignored
// - bit 0 write of 1 forces reset
`timescale 1ns/1ps
module rcd_reset_cause #(
	parameter int HOLD_CYCLES = rcd_pkg::RESET_HOLD_CYCLES
) (
	input  wire logic                       clock_in,
	input  wire logic                       arst_n_in,
	input  wire logic                       reset_pin_n_in,
	input  wire logic                       low_voltage_trip_in,
	input  wire logic                       watchdog_timeout_in,
	input  wire logic                       watchdog_enable_in,
	input  wire logic                       unimpl_opcode_in,
	input  wire logic                       stop_instr_in,
	input  wire logic                       stop_mode_enable_in,
	input  wire logic                       background_entry_instruction_in,
	input  wire logic                       debug_mode_enable_in,
	input  wire logic                       clock_gen_reset_in,
	input  wire logic                       low_voltage_detect_enable_in,
	input  wire logic                       low_voltage_reset_enable_in,
	input  wire logic                       low_voltage_stop_enable_in,
	input  wire logic                       stop_mode_in,
	input  wire logic [rcd_pkg::ADDR_W-1:0] bus_addr_in,
	input  wire logic                       bus_wr_in,
	input  wire logic                       bus_rd_in,
	input  wire logic [rcd_pkg::DATA_W-1:0] bus_wdata_in,
	input  wire logic                       bus_debug_in,
	output logic                            system_reset_out,
	output logic                            watchdog_restart_out,
	output logic [rcd_pkg::DATA_W-1:0]      bus_rdata_out
);

	rcd_pkg::rcd_state_t              state;
	rcd_pkg::rcd_src_t                src;
	logic [rcd_pkg::HOLD_CNT_W-1:0]   hold_cnt;
	logic                             pin_level;
	logic                             lv_trip;
	logic                             lv_armed;
	logic                             force_req;
	logic                             other_go;
	logic                             trigger;
	logic                             bus_ok;
	logic                             flag_por;
	logic                             flag_pin;
	logic                             flag_wdog;
	logic                             flag_illegal;
	logic                             flag_clkgen;
	logic                             flag_lv;
	logic [rcd_pkg::DATA_W-1:0]       status_value;

	rcd_pin_sync #(
		.IDLE (rcd_pkg::PIN_IDLE)
	) u_pin_sync (
		.clock_in  (clock_in),
		.arst_n_in (arst_n_in),
		.level_in  (reset_pin_n_in),
		.level_out (pin_level)
	);

	rcd_pin_sync #(
		.IDLE (rcd_pkg::LV_TRIP_IDLE)
	) u_lv_sync (
		.clock_in  (clock_in),
		.arst_n_in (arst_n_in),
		.level_in  (low_voltage_trip_in),
		.level_out (lv_trip)
	);

	assign lv_armed = lv_trip & low_voltage_detect_enable_in & low_voltage_reset_enable_in
		& (~stop_mode_in | low_voltage_stop_enable_in);

	always_comb
	begin
		src.pin  = ~pin_level;
		src.wdog = watchdog_timeout_in & watchdog_enable_in;
		src.illegal = unimpl_opcode_in | (stop_instr_in & ~stop_mode_enable_in)
			| (background_entry_instruction_in & ~debug_mode_enable_in);
		src.clkgen = clock_gen_reset_in;
		src.lvr  = lv_armed;
		src.dbg  = force_req;
	end

	assign other_go = src.pin | src.wdog | src.illegal | src.clkgen;
	assign trigger  = (state == rcd_pkg::st_run) & (other_go | src.lvr | src.dbg);
	assign bus_ok   = (state == rcd_pkg::st_run);

	localparam int HOLD_CNT_W = rcd_pkg::HOLD_CNT_W;

	// reset sequencing
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state    <= rcd_pkg::st_hold;
			hold_cnt <= '0;
		end
		else
		begin
			case (state)
				rcd_pkg::st_run:
					if (trigger)
					begin
						state    <= rcd_pkg::st_hold;
						hold_cnt <= HOLD_CNT_W'(HOLD_CYCLES - 1);
					end
				rcd_pkg::st_hold:
					if (hold_cnt != '0)
						hold_cnt <= hold_cnt - 1'b1;
					else if (!lv_armed)
						state <= rcd_pkg::st_run;
				default:
					state <= rcd_pkg::st_hold;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			system_reset_out <= 1'b1;
		else
			system_reset_out <= trigger | ((state == rcd_pkg::st_hold) & ((hold_cnt != '0) | lv_armed));
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			flag_por  <= rcd_pkg::POR_FLAG_RST;
			flag_lv   <= rcd_pkg::LV_FLAG_RST;
			flag_pin  <= rcd_pkg::SRC_FLAG_RST;
			flag_wdog <= rcd_pkg::SRC_FLAG_RST;
			flag_illegal <= rcd_pkg::SRC_FLAG_RST;
			flag_clkgen  <= rcd_pkg::SRC_FLAG_RST;
		end
		else if (trigger)
		begin
			if (src.lvr)
			begin
				flag_lv   <= 1'b1;
				flag_pin  <= 1'b0;
				flag_wdog <= 1'b0;
				flag_illegal <= 1'b0;
				flag_clkgen  <= 1'b0;
			end
			else
			begin
				flag_por  <= 1'b0;
				flag_lv   <= 1'b0;
				flag_pin  <= src.pin;
				flag_wdog <= src.wdog;
				flag_illegal <= src.illegal;
				flag_clkgen  <= src.clkgen;
			end
		end
	end

	always_comb
	begin
		status_value                   = '0;
		status_value[rcd_pkg::BIT_POR]  = flag_por;
		status_value[rcd_pkg::BIT_PIN]  = flag_pin;
		status_value[rcd_pkg::BIT_WDOG] = flag_wdog;
		status_value[rcd_pkg::BIT_ILLEGAL] = flag_illegal;
		status_value[rcd_pkg::BIT_CLKGEN]  = flag_clkgen;
		status_value[rcd_pkg::BIT_LV]   = flag_lv;
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			watchdog_restart_out <= 1'b0;
		else
			watchdog_restart_out <= bus_ok & bus_wr_in & (bus_addr_in == rcd_pkg::STATUS_ADDR);
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			force_req <= 1'b0;
		else
			force_req <= bus_ok & bus_wr_in & bus_debug_in & (bus_addr_in == rcd_pkg::FORCE_ADDR)
				& bus_wdata_in[rcd_pkg::BIT_FORCE];
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			bus_rdata_out <= '0;
		else if (bus_ok & bus_rd_in)
		begin
			case (bus_addr_in)
				rcd_pkg::STATUS_ADDR: bus_rdata_out <= status_value;
				rcd_pkg::FORCE_ADDR:  bus_rdata_out <= rcd_pkg::FORCE_READ_VAL;
				default:              bus_rdata_out <= rcd_pkg::UNMAPPED_READ_VAL;
			endcase
		end
	end

	property p_dbg_clear;
		@(posedge clock_in) disable iff (!arst_n_in)
		(trigger & src.dbg & ~other_go & ~src.lvr) |=> (status_value == 8'h00);
	endproperty
	a_dbg_clear: assert property (p_dbg_clear) else $error("debug reset left a flag set");

	property p_wdog_restart;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & bus_wr_in & (bus_addr_in == rcd_pkg::STATUS_ADDR) & ~trigger)
			|=> watchdog_restart_out && (status_value == $past(status_value));
	endproperty
	a_wdog_restart: assert property (p_wdog_restart) else $error("status write misbehaved");

	property p_lv_reset;
		@(posedge clock_in) disable iff (!arst_n_in)
		(trigger & src.lvr) |=> flag_lv && (flag_por == $past(flag_por))
			&& !flag_pin && !flag_wdog && !flag_illegal && !flag_clkgen;
	endproperty
	a_lv_reset: assert property (p_lv_reset) else $error("low-voltage flags wrong");

	property p_other_reset;
		@(posedge clock_in) disable iff (!arst_n_in)
		(trigger & ~src.lvr) |=> !flag_por && !flag_lv && (flag_pin == $past(~pin_level))
			&& (flag_wdog == $past(watchdog_timeout_in & watchdog_enable_in))
			&& (flag_clkgen == $past(clock_gen_reset_in));
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("source flags wrong");

	property p_illegal_stop;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & ~src.lvr & stop_instr_in & ~stop_mode_enable_in) |=> flag_illegal && system_reset_out;
	endproperty
	a_illegal_stop: assert property (p_illegal_stop) else $error("illegal stop not flagged");

	property p_lv_enable;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & ~other_go & ~force_req & ~low_voltage_reset_enable_in) |=> !system_reset_out;
	endproperty
	a_lv_enable: assert property (p_lv_enable) else $error("low-voltage reset without enable");

	property p_force_read;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & bus_rd_in & (bus_addr_in == rcd_pkg::FORCE_ADDR)) |=> (bus_rdata_out == 8'h00);
	endproperty
	a_force_read: assert property (p_force_read) else $error("force register read nonzero");

	property p_user_ignored;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_wr_in & ~bus_debug_in) |=> !force_req;
	endproperty
	a_user_ignored: assert property (p_user_ignored) else $error("user write forced reset");

	property p_force_reset;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & bus_wr_in & bus_debug_in & (bus_addr_in == rcd_pkg::FORCE_ADDR) & bus_wdata_in[0] & ~trigger)
			|=> force_req ##1 system_reset_out;
	endproperty
	a_force_reset: assert property (p_force_reset) else $error("debug force did not reset");

	property p_unimpl_zero;
		@(posedge clock_in) disable iff (!arst_n_in)
		(bus_ok & bus_rd_in & (bus_addr_in == rcd_pkg::STATUS_ADDR)) |=> !bus_rdata_out[3] && !bus_rdata_out[0];
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented status bit set");

	property p_flags_hold;
		@(posedge clock_in) disable iff (!arst_n_in)
		!trigger |=> $stable(status_value);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed without reset");

endmodule // rcd_reset_cause

/* File: testbench/rcd_dbg_host.sv */
// debug host model that issues parallel background writes to the force register
// assumes the bench merges its strobes onto the register port of the block
`timescale 1ns/1ps
module rcd_dbg_host (
	input  wire logic       clock_in,
	input  wire logic       go_in,
	input  wire logic [7:0] value_in,
	output logic            wr_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	output logic            debug_out
);
	always @(posedge clock_in)
	begin
		wr_out <= go_in;
		debug_out <= go_in;
		addr_out <= go_in ? rcd_pkg::FORCE_ADDR : ~rcd_pkg::FORCE_ADDR;
		wdata_out <= go_in ? value_in : ~value_in;
	end
endmodule // rcd_dbg_host

/* File: testbench/testbench.sv */
// self-checking bench for the reset cause block
// assumes rcd_pkg, the design files and the debug host model are compiled first
`timescale 1ns/1ps
module testbench;
	logic       clk, rst_n, pin_n, wd_to, wd_en, unimpl, stp, stp_en, bg, dm_en, clkgen;
	logic       lv, lv_de, lv_re, lv_se, stp_mode, rd, wr, dbg, go, h_wr, h_dbg, sys_rst, wd_rst;
	logic [7:0] addr, wdata, rdata, hval, h_addr, h_wdata;
	int         miscompares = 0;
	int         num_checks = 0;
	int         cyc = 0;

	rcd_reset_cause #(.HOLD_CYCLES(6)) u_dut (
		.clock_in(clk), .arst_n_in(rst_n), .reset_pin_n_in(pin_n), .low_voltage_trip_in(lv),
		.watchdog_timeout_in(wd_to), .watchdog_enable_in(wd_en), .unimpl_opcode_in(unimpl),
		.stop_instr_in(stp), .stop_mode_enable_in(stp_en), .background_entry_instruction_in(bg),
		.debug_mode_enable_in(dm_en), .clock_gen_reset_in(clkgen), .low_voltage_detect_enable_in(lv_de),
		.low_voltage_reset_enable_in(lv_re), .low_voltage_stop_enable_in(lv_se), .stop_mode_in(stp_mode),
		.bus_addr_in(h_wr ? h_addr : addr), .bus_wr_in(wr | h_wr), .bus_rd_in(rd),
		.bus_wdata_in(h_wr ? h_wdata : wdata), .bus_debug_in(h_wr ? h_dbg : dbg),
		.system_reset_out(sys_rst), .watchdog_restart_out(wd_rst), .bus_rdata_out(rdata));

	rcd_dbg_host u_host (.clock_in(clk), .go_in(go), .value_in(hval), .wr_out(h_wr), .addr_out(h_addr),
		.wdata_out(h_wdata), .debug_out(h_dbg));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		while (sys_rst !== 1'b0 && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(8'(sys_rst), 8'h00);
	endtask

	task automatic power_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		wait_run;
	endtask

	task automatic trig(input logic [6:0] s, input logic er, input logic [7:0] es);
		int n;
		@(posedge clk);
		{pin_n, wd_to, unimpl, stp, bg, clkgen, lv} <= s ^ 7'h40;
		n = 0;
		while (sys_rst !== 1'b1 && n < 10)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(8'(sys_rst), 8'(er));
		@(posedge clk);
		{pin_n, wd_to, unimpl, stp, bg, clkgen, lv} <= 7'h40;
		#1;
		wait_run;
		acc(1'b0, rcd_pkg::STATUS_ADDR, 8'h00);
		chk(rdata, es);
		$display("source test %h done", s);
	endtask

	task automatic host_wr(input logic [7:0] v, input logic er);
		@(posedge clk);
		go <= 1'b1;
		hval <= v;
		@(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(8'(sys_rst), 8'(er));
		wait_run;
	endtask

	task automatic t_regs;
		acc(1'b0, rcd_pkg::STATUS_ADDR, 8'h00);
		chk(rdata, 8'h82);
		acc(1'b0, rcd_pkg::FORCE_ADDR, 8'h00);
		chk(rdata, 8'h00);
		acc(1'b0, 8'h05, 8'h00);
		chk(rdata, 8'h00);
		acc(1'b1, rcd_pkg::STATUS_ADDR, 8'hff);
		chk(8'(wd_rst), 8'h01);
		@(posedge clk);
		#1;
		chk(8'(wd_rst), 8'h00);
		acc(1'b0, rcd_pkg::STATUS_ADDR, 8'h00);
		chk(rdata, 8'h82);
		$display("register test done");
	endtask

	task automatic t_force;
		acc(1'b1, rcd_pkg::FORCE_ADDR, 8'h01);
		repeat (5) @(posedge clk);
		#1;
		chk(8'(sys_rst), 8'h00);
		host_wr(8'hfe, 1'b0);
		host_wr(8'h01, 1'b1);
		acc(1'b0, rcd_pkg::STATUS_ADDR, 8'h00);
		chk(rdata, 8'h00);
		$display("force test done");
	endtask

	task automatic t_src;
		wd_en <= 1'b0;
		trig(7'h20, 1'b0, 8'h00);
		wd_en <= 1'b1;
		trig(7'h20, 1'b1, 8'h20);
		trig(7'h40, 1'b1, 8'h40);
		trig(7'h04, 1'b1, 8'h10);
		trig(7'h02, 1'b1, 8'h04);
		trig(7'h08, 1'b1, 8'h10);
		trig(7'h10, 1'b1, 8'h10);
		stp_en <= 1'b1;
		dm_en <= 1'b1;
		trig(7'h0c, 1'b0, 8'h10);
		trig(7'h22, 1'b1, 8'h24);
		lv_re <= 1'b0;
		trig(7'h01, 1'b0, 8'h24);
		lv_re <= 1'b1;
		trig(7'h01, 1'b1, 8'h02);
		stp_mode <= 1'b1;
		trig(7'h01, 1'b0, 8'h02);
		lv_se <= 1'b1;
		trig(7'h01, 1'b1, 8'h02);
		power_reset;
		trig(7'h01, 1'b1, 8'h82);
		trig(7'h40, 1'b1, 8'h40);
		$display("source tests done");
	endtask

	initial
	begin
		{rst_n, pin_n, wd_to, unimpl, stp, bg, clkgen, lv, stp_mode, lv_se} = 10'h100;
		{wd_en, stp_en, dm_en, lv_de, lv_re, rd, wr, dbg, go} = 9'h130;
		dbg = 1'b0;
		pin_n = 1'b1;
		{addr, wdata, hval} = 24'h000000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		wait_run;
		t_regs;
		t_force;
		t_src;
		wrap_up;
	end
endmodule // testbench
